/* File: rtl/mah_pkg.sv */
`default_nettype none

package mah_pkg;

    // Reference clock period in picoseconds (200 MHz)
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PS_PER_NS     = 1000;

    // Pin-level times, as printed
    localparam int SH_LOW_NS     = 150;  // Least sample/hold low time, first mode
    localparam int MUX_SETUP_NS  = 75;   // Channel lines settled before sample/hold falls
    localparam int SETTLE_NS     = 20;   // Data valid after conversion-done falls
    localparam int RECOVER_NS    = 50;   // Gap from end of conversion to next start
    localparam int TIMEOUT_NS    = 2000; // Longest wait for conversion-done

    // Least times round up, the longest time rounds down
    localparam int SH_LOW_CYC    = (SH_LOW_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MUX_SETUP_CYC = (MUX_SETUP_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_CYC    = (SETTLE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVER_CYC   = (RECOVER_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMEOUT_CYC   = (TIMEOUT_NS * PS_PER_NS) / CLK_PERIOD_PS;

    localparam int SYNC_STAGES   = 2;
    localparam int DATA_W        = 10;
    localparam int CNT_W         = 10;

    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
    localparam logic [DATA_W-1:0] DATA_RST = 10'h000;

    typedef logic [CNT_W-1:0] mah_cnt_t;

    // Converter pins driven by the host
    typedef struct packed {
        logic cs_n;
        logic sh_n;
        logic rd_n;
        logic chan_sel_hi;
        logic chan_sel_lo;
    } mah_pins_t;

    localparam mah_pins_t PINS_IDLE = '{cs_n: 1'b1, sh_n: 1'b1, rd_n: 1'b1, chan_sel_hi: 1'b0, chan_sel_lo: 1'b0};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SAMPLE,
        ST_WAIT_DONE,
        ST_SETTLE,
        ST_RECOVER
    } mah_state_t;

endpackage

`default_nettype wire

/* File: rtl/mah_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin inputs
module mah_sync #(
    parameter int WIDTH  = 1,
    parameter bit RST_HI = 1'b0
) (
    input  wire logic             ref_clk, // Clock
    input  wire logic             resetn,  // Synchronous reset
    input  wire logic [WIDTH-1:0] d,       // Asynchronous input
    output logic      [WIDTH-1:0] q        // Synchronised output
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_r <= {WIDTH{RST_HI}};
            q      <= {WIDTH{RST_HI}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/mah_host.sv */
`timescale 1ns/1ps
`default_nettype none

module mah_host (
    input  wire logic                       ref_clk,     // 200 MHz clock
    input  wire logic                       resetn,      // Synchronous reset, active low
    input  wire logic                       start,       // Start one conversion
    input  wire logic [1:0]                 chan,        // Requested channel
    input  wire logic                       mode_rd,     // 1: tied-strobe mode
    input  wire logic                       four_chan,   // 1: four-input variant
    output logic                            busy,        // Conversion in progress
    output logic                            done,        // Result valid pulse
    output logic                            timeout_err, // Conversion-done never came
    output logic [mah_pkg::DATA_W-1:0]      result,      // Last result
    output logic                            cs_n,        // Chip select pin
    output logic                            sh_n,        // Sample/hold pin
    output logic                            rd_n,        // Read pin
    output logic                            chan_sel_hi, // Channel select high pin
    output logic                            chan_sel_lo, // Channel select low pin
    input  wire logic                       int_n,       // Conversion-done pin
    input  wire logic [mah_pkg::DATA_W-1:0] adc_data     // Converter data pins
);

    localparam mah_pkg::mah_cnt_t SH_LOW    = mah_pkg::mah_cnt_t'(mah_pkg::SH_LOW_CYC);
    localparam mah_pkg::mah_cnt_t MUX_SETUP = mah_pkg::mah_cnt_t'(mah_pkg::MUX_SETUP_CYC);
    localparam mah_pkg::mah_cnt_t SETTLE    = mah_pkg::mah_cnt_t'(mah_pkg::SETTLE_CYC + mah_pkg::SYNC_STAGES);
    localparam mah_pkg::mah_cnt_t RECOVER   = mah_pkg::mah_cnt_t'(mah_pkg::RECOVER_CYC);
    localparam mah_pkg::mah_cnt_t TIMEOUT   = mah_pkg::mah_cnt_t'(mah_pkg::TIMEOUT_CYC);

    mah_pkg::mah_state_t            state_r;
    mah_pkg::mah_pins_t             pins_r;
    mah_pkg::mah_cnt_t              cnt_r;
    logic                           mode_rd_r;
    logic                           int_s;
    logic [mah_pkg::DATA_W-1:0]     data_s;
    logic                           cnt_hit;

    mah_sync #(.WIDTH(1), .RST_HI(1'b1)) u_sync_int (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       (int_n),
        .q       (int_s)
    );

    mah_sync #(.WIDTH(mah_pkg::DATA_W), .RST_HI(1'b0)) u_sync_data (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       (adc_data),
        .q       (data_s)
    );

    localparam mah_pkg::mah_cnt_t CNT_LAST = mah_pkg::CNT_ONE;
    assign cnt_hit = (cnt_r == CNT_LAST);

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r   <= mah_pkg::ST_IDLE;
            cnt_r     <= mah_pkg::CNT_ZERO;
            mode_rd_r <= 1'b0;
        end else begin
            if (cnt_r != mah_pkg::CNT_ZERO) begin
                cnt_r <= cnt_r - mah_pkg::CNT_ONE;
            end
            case (state_r)
                mah_pkg::ST_IDLE: begin
                    if (start) begin
                        mode_rd_r <= mode_rd;
                        cnt_r     <= MUX_SETUP;
                        state_r   <= mah_pkg::ST_SETUP;
                    end
                end
                mah_pkg::ST_SETUP: begin
                    if (cnt_hit) begin
                        cnt_r   <= mode_rd_r ? TIMEOUT : SH_LOW;
                        state_r <= mode_rd_r ? mah_pkg::ST_WAIT_DONE : mah_pkg::ST_SAMPLE;
                    end
                end
                mah_pkg::ST_SAMPLE: begin
                    if (cnt_hit) begin
                        cnt_r   <= TIMEOUT;
                        state_r <= mah_pkg::ST_WAIT_DONE;
                    end
                end
                mah_pkg::ST_WAIT_DONE: begin
                    if (!int_s) begin
                        cnt_r   <= SETTLE;
                        state_r <= mah_pkg::ST_SETTLE;
                    end else if (cnt_hit) begin
                        cnt_r   <= RECOVER;
                        state_r <= mah_pkg::ST_RECOVER;
                    end
                end
                mah_pkg::ST_SETTLE: begin
                    if (cnt_hit) begin
                        cnt_r   <= RECOVER;
                        state_r <= mah_pkg::ST_RECOVER;
                    end
                end
                mah_pkg::ST_RECOVER: begin
                    if (cnt_r == mah_pkg::CNT_ZERO && int_s) begin
                        state_r <= mah_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= mah_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pin drive
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pins_r <= mah_pkg::PINS_IDLE;
        end else begin
            case (state_r)
                mah_pkg::ST_IDLE: begin
                    if (start) begin
                        pins_r.cs_n        <= 1'b0;
                        pins_r.chan_sel_lo <= chan[0];
                        pins_r.chan_sel_hi <= four_chan & chan[1];
                    end
                end
                mah_pkg::ST_SETUP: begin
                    if (cnt_hit) begin
                        pins_r.sh_n <= 1'b0;
                        pins_r.rd_n <= ~mode_rd_r;
                    end
                end
                mah_pkg::ST_SAMPLE: begin
                    if (cnt_hit) begin
                        pins_r.sh_n <= 1'b1;
                    end
                end
                mah_pkg::ST_WAIT_DONE: begin
                    if (!int_s) begin
                        pins_r.rd_n <= 1'b0;
                    end else if (cnt_hit) begin
                        pins_r <= mah_pkg::PINS_IDLE;
                    end
                end
                mah_pkg::ST_SETTLE: begin
                    if (cnt_hit) begin
                        pins_r <= mah_pkg::PINS_IDLE;
                    end
                end
                mah_pkg::ST_RECOVER: begin
                    pins_r <= mah_pkg::PINS_IDLE;
                end
                default: begin
                    pins_r <= mah_pkg::PINS_IDLE;
                end
            endcase
        end
    end

    // Result capture and status
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            result      <= mah_pkg::DATA_RST;
            done        <= 1'b0;
            timeout_err <= 1'b0;
            busy        <= 1'b0;
        end else begin
            done        <= 1'b0;
            timeout_err <= 1'b0;
            busy        <= (state_r != mah_pkg::ST_IDLE) || start;
            if (state_r == mah_pkg::ST_SETTLE && cnt_hit) begin
                result <= data_s;
                done   <= 1'b1;
            end
            if (state_r == mah_pkg::ST_WAIT_DONE && int_s && cnt_hit) begin
                timeout_err <= 1'b1;
            end
        end
    end

    assign cs_n        = pins_r.cs_n;
    assign sh_n        = pins_r.sh_n;
    assign rd_n        = pins_r.rd_n;
    assign chan_sel_hi = pins_r.chan_sel_hi;
    assign chan_sel_lo = pins_r.chan_sel_lo;

    // Helper counters for checks
    mah_pkg::mah_cnt_t sh_low_cnt_r;
    mah_pkg::mah_cnt_t int_low_cnt_r;
    logic [1:0]        chan_req_r;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sh_low_cnt_r  <= mah_pkg::CNT_ZERO;
            int_low_cnt_r <= mah_pkg::CNT_ZERO;
            chan_req_r    <= 2'h0;
        end else begin
            sh_low_cnt_r  <= pins_r.sh_n ? mah_pkg::CNT_ZERO : sh_low_cnt_r + mah_pkg::CNT_ONE;
            int_low_cnt_r <= int_s ? mah_pkg::CNT_ZERO : int_low_cnt_r + mah_pkg::CNT_ONE;
            if (start && state_r == mah_pkg::ST_IDLE) begin
                chan_req_r <= {four_chan & chan[1], chan[0]};
            end
        end
    end

    property p_sh_min_low;
        @(posedge ref_clk) disable iff (!resetn)
        ($rose(pins_r.sh_n) && !mode_rd_r) |-> (sh_low_cnt_r >= SH_LOW);
    endproperty
    a_sh_min_low: assert property (p_sh_min_low) else $error("sample/hold low too short");

    property p_tied_strobes;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_rd_r && state_r != mah_pkg::ST_IDLE && state_r != mah_pkg::ST_RECOVER) |-> (pins_r.sh_n == pins_r.rd_n);
    endproperty
    a_tied_strobes: assert property (p_tied_strobes) else $error("strobes not tied");

    property p_chan_setup;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(pins_r.sh_n) |-> ({pins_r.chan_sel_hi, pins_r.chan_sel_lo} == chan_req_r)
                               && $stable({pins_r.chan_sel_hi, pins_r.chan_sel_lo});
    endproperty
    a_chan_setup: assert property (p_chan_setup) else $error("channel lines not set up");

    property p_chan_index;
        @(posedge ref_clk) disable iff (!resetn)
        (start && state_r == mah_pkg::ST_IDLE && four_chan) |=> ({pins_r.chan_sel_hi, pins_r.chan_sel_lo} == $past(chan));
    endproperty
    a_chan_index: assert property (p_chan_index) else $error("channel index wrong");

    property p_two_chan_hi_low;
        @(posedge ref_clk) disable iff (!resetn)
        (start && state_r == mah_pkg::ST_IDLE && !four_chan) |=> !pins_r.chan_sel_hi;
    endproperty
    a_two_chan_hi_low: assert property (p_two_chan_hi_low) else $error("high channel line used");

    property p_settle;
        @(posedge ref_clk) disable iff (!resetn)
        done |-> ($past(int_low_cnt_r) >= SETTLE - mah_pkg::CNT_ONE) && $past(!pins_r.cs_n && !pins_r.rd_n);
    endproperty
    a_settle: assert property (p_settle) else $error("result taken too early");

    c_mode1_done: cover property (@(posedge ref_clk) disable iff (!resetn) done && !mode_rd_r);
    c_mode2_done: cover property (@(posedge ref_clk) disable iff (!resetn) done && mode_rd_r);
    c_chan3_done: cover property (@(posedge ref_clk) disable iff (!resetn) done && chan_req_r == 2'h3);
    c_timeout:    cover property (@(posedge ref_clk) disable iff (!resetn) timeout_err);

endmodule

`default_nettype wire

/* File: bench/mah_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Converter model; conversion times are the typical figures
module mah_conv_model (
    input  wire logic                       cs_n,        // Chip select pin
    input  wire logic                       sh_n,        // Sample/hold pin
    input  wire logic                       rd_n,        // Read pin
    input  wire logic                       chan_sel_hi, // Channel select high pin
    input  wire logic                       chan_sel_lo, // Channel select low pin
    input  wire logic                       mute,        // Withhold conversion-done
    output logic                            int_n,       // Conversion-done pin
    output logic [mah_pkg::DATA_W-1:0]      adc_data     // Data pins
);
    logic [1:0]                 ch_r;
    logic [7:0]                 seq_r;
    logic [mah_pkg::DATA_W-1:0] dout_r;
    logic                       mode2_r;

    initial begin
        int_n   = 1'b1;
        ch_r    = 2'h0;
        seq_r   = 8'h00;
        mode2_r = 1'b0;
        dout_r  = 10'h155;
    end

    // Result word: channel in the top bits, conversion count below
    task automatic convert(input int ns);
        #(ns);
        if (!mute) begin
            int_n  = 1'b0;
            dout_r = ~{ch_r, seq_r};
            #20;
            dout_r = {ch_r, seq_r};
        end
    endtask

    always @(negedge sh_n) begin
        if (!cs_n) begin
            ch_r  = {chan_sel_hi, chan_sel_lo};
            seq_r = seq_r + 8'h01;
            #1;
            mode2_r = !rd_n;
            if (mode2_r) begin
                // With the step above, the flag lands 1 ns past a clock edge
                convert(470);
            end
        end
    end

    always @(posedge sh_n) begin
        if (!cs_n && !mode2_r) begin
            // Step off the clock edge so the host never samples a changing pin
            #1;
            convert(360);
        end
    end

    always @(posedge rd_n) begin
        int_n = 1'b1;
    end

    // Released pins show the inverse of the last value
    assign adc_data = (!cs_n && !rd_n) ? dout_r : ~dout_r;
endmodule

`default_nettype wire

/* File: bench/test_mah_host.sv */
`timescale 1ns/1ps
`default_nettype none

module test_mah_host;
    logic                       ref_clk;
    logic                       resetn;
    logic                       start;
    logic [1:0]                 chan;
    logic                       mode_rd;
    logic                       four_chan;
    logic                       mute;
    logic                       busy;
    logic                       done;
    logic                       timeout_err;
    logic [mah_pkg::DATA_W-1:0] result;
    logic                       cs_n;
    logic                       sh_n;
    logic                       rd_n;
    logic                       chan_sel_hi;
    logic                       chan_sel_lo;
    logic                       int_n;
    logic [mah_pkg::DATA_W-1:0] adc_data;
    logic [7:0]                 seq_exp;
    logic [mah_pkg::DATA_W-1:0] res;
    int                         sh_low;
    int                         error_cnt;
    int                         comparisons;

    mah_host i_mah_host (.ref_clk(ref_clk), .resetn(resetn), .start(start), .chan(chan), .mode_rd(mode_rd),
        .four_chan(four_chan), .busy(busy), .done(done), .timeout_err(timeout_err), .result(result),
        .cs_n(cs_n), .sh_n(sh_n), .rd_n(rd_n), .chan_sel_hi(chan_sel_hi), .chan_sel_lo(chan_sel_lo),
        .int_n(int_n), .adc_data(adc_data));

    mah_conv_model i_mah_conv_model (.cs_n(cs_n), .sh_n(sh_n), .rd_n(rd_n), .chan_sel_hi(chan_sel_hi),
        .chan_sel_lo(chan_sel_lo), .mute(mute), .int_n(int_n), .adc_data(adc_data));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({9'h000, busy}, 10'h000);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic pulse_start(input logic [1:0] c, input logic m2, input logic f4);
        @(posedge ref_clk);
        start     <= 1'b1;
        chan      <= c;
        mode_rd   <= m2;
        four_chan <= f4;
        @(posedge ref_clk);
        start   <= 1'b0;
        seq_exp = seq_exp + 8'h01;
    endtask

    task automatic run_conv(input logic [1:0] c, input logic m2, input logic f4);
        int n;
        n      = 0;
        sh_low = 0;
        pulse_start(c, m2, f4);
        do begin
            @(posedge ref_clk);
            #1;
            if (sh_n === 1'b0) sh_low++;
            n++;
        end while (done !== 1'b1 && n < 1000);
        chk({9'h000, done}, 10'h001);
        res = result;
        wait_idle();
    endtask

    task automatic t_reset();
        chk({5'h00, cs_n, sh_n, rd_n, chan_sel_hi, chan_sel_lo}, 10'h01c);
        chk({8'h00, busy, done}, 10'h000);
    endtask

    task automatic t_mode1();
        for (int c = 0; c < 4; c++) begin
            run_conv(2'(c), 1'b0, 1'b1);
            chk(res, {2'(c), seq_exp});
            chk(10'(sh_low), 10'(mah_pkg::SH_LOW_CYC));
        end
    endtask

    task automatic t_mode2();
        for (int c = 3; c >= 0; c--) begin
            run_conv(2'(c), 1'b1, 1'b1);
            chk(res, {2'(c), seq_exp});
        end
    endtask

    task automatic t_two_input();
        run_conv(2'b11, 1'b0, 1'b0);
        chk(res, {2'b01, seq_exp});
        run_conv(2'b10, 1'b1, 1'b0);
        chk(res, {2'b00, seq_exp});
    endtask

    task automatic t_refuse();
        pulse_start(2'b10, 1'b0, 1'b1);
        repeat (5) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        wait_idle();
        repeat (20) @(posedge ref_clk);
        #1;
        chk({9'h000, busy}, 10'h000);
        run_conv(2'b01, 1'b0, 1'b1);
        chk(res, {2'b01, seq_exp});
    endtask

    task automatic t_timeout();
        int  n;
        logic seen;
        n    = 0;
        seen = 1'b0;
        mute <= 1'b1;
        pulse_start(2'b00, 1'b0, 1'b1);
        while (!seen && n < 700) begin
            @(posedge ref_clk);
            #1;
            if (timeout_err === 1'b1) seen = 1'b1;
            n++;
        end
        chk({9'h000, seen}, 10'h001);
        mute <= 1'b0;
        wait_idle();
        run_conv(2'b11, 1'b1, 1'b1);
        chk(res, {2'b11, seq_exp});
    endtask

    initial begin
        #100_000;
        error_cnt++;
        complete_run();
    end

    initial begin
        error_cnt   = 0;
        comparisons = 0;
        seq_exp     = 8'h00;
        resetn      = 1'b0;
        start       = 1'b0;
        chan        = 2'h0;
        mode_rd     = 1'b0;
        four_chan   = 1'b1;
        mute        = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        t_reset();
        @(posedge ref_clk);
        resetn <= 1'b1;
        t_mode1();
        t_mode2();
        t_two_input();
        t_refuse();
        t_timeout();
        complete_run();
    end
endmodule

`default_nettype wire
